// [rtl/dps_map.svh]
// Timing and sizing constants for the dual-port burst SRAM port
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

`define DPS_CLK_PERIOD_NS   25
`define DPS_K_PERIOD_NS     200
`define DPS_K_DIV           (`DPS_K_PERIOD_NS / `DPS_CLK_PERIOD_NS)
`define DPS_K_SETUP_PH      6
`define DPS_KN_SETUP_PH     2
`define DPS_DLL_LOCK_CYC    1024
`define DPS_WORD_W          36
`define DPS_MASK_W          4
`define DPS_ADDR_W          20
`define DPS_NIB_W           2
`define DPS_BURST_LEN       2
`define DPS_STRAP_CYC       2

`endif

// [rtl/dps_pkg.sv]
// Types shared by both ends of the burst SRAM port
`default_nettype none
package dps_pkg;
    typedef enum logic [1:0] {
        DPS_OUT_IDLE,
        DPS_OUT_WORD0,
        DPS_OUT_WORD1
    } dps_out_state_t;
    typedef logic [1:0] dps_burst_idx_t;
endpackage : dps_pkg
`default_nettype wire

// [rtl/dps_if.sv]
// Link between host memory controller and SRAM port
`include "dps_map.svh"
`default_nettype none
interface dps_if #(
    parameter int WORD_W = `DPS_WORD_W,
    parameter int MASK_W = `DPS_MASK_W,
    parameter int ADDR_W = `DPS_ADDR_W
);
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              read_select_n;
    logic              write_select_n;
    logic [ADDR_W-1:0] shared_address_bus;
    logic [WORD_W-1:0] write_data_in;
    logic [MASK_W-1:0] byte_write_mask_n;
    logic [1:0]        nibble_write_mask_n;
    logic              delay_lock_off_n;
    logic [WORD_W-1:0] read_data_out;
    logic              read_data_oe;
    logic              echo_clock_out;
    logic              echo_clock_out_n;
    wire  [WORD_W-1:0] read_data_bus;

    // Released pins show the inverse of the last word, so stale data is not taken
    assign read_data_bus = read_data_oe ? read_data_out : ~read_data_out;

    modport dev (
        input  k, k_n, c, c_n, read_select_n, write_select_n, shared_address_bus,
               write_data_in, byte_write_mask_n, nibble_write_mask_n, delay_lock_off_n,
        output read_data_out, read_data_oe, echo_clock_out, echo_clock_out_n
    );
    modport host (
        output k, k_n, c, c_n, read_select_n, write_select_n, shared_address_bus,
               write_data_in, byte_write_mask_n, nibble_write_mask_n, delay_lock_off_n,
        input  read_data_bus, read_data_oe, echo_clock_out, echo_clock_out_n
    );
endinterface : dps_if
`default_nettype wire

// [rtl/dps_sync.sv]
// Two-flop synchroniser for pin inputs
`default_nettype none
module dps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : dps_sync
`default_nettype wire

// [rtl/dps_dev.sv]
// Device end: burst SRAM port with separate read and write data ports
`include "dps_map.svh"
`default_nettype none
module dps_dev #(
    parameter int WORD_W = `DPS_WORD_W,
    parameter int MASK_W = `DPS_MASK_W,
    parameter int ADDR_W = `DPS_ADDR_W,
    parameter int DLL_LOCK_CYC = `DPS_DLL_LOCK_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Link
    dps_if.dev        lnk,
    // Status
    output logic      dll_locked,
    output logic      single_clock_mode,
    output dps_pkg::dps_out_state_t out_state
);
    import dps_pkg::*;

    localparam int LANE_W = (WORD_W == 8) ? 4 : WORD_W / MASK_W;
    localparam int NLANE  = WORD_W / LANE_W;
    localparam int IN_W   = 7 + ADDR_W + WORD_W + MASK_W + `DPS_NIB_W;
    localparam int DEPTH  = 2 ** ADDR_W;

    logic [IN_W-1:0]   in_s;
    logic              k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s, dll_off_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [WORD_W-1:0] d_s;
    logic [MASK_W-1:0] bw_n_s;
    logic [1:0]        nw_n_s;
    logic              k_p_r, kn_p_r, c_p_r, cn_p_r;
    logic              k_rise, kn_rise, oc_rise, ocn_rise;
    logic [1:0]        strap_cnt_r;
    logic              single_r;
    logic              rd_pend_r, rd_arm_r;
    logic [ADDR_W-1:0] rd_pend_addr_r, rd_arm_addr_r, rd_w1_addr_r;
    logic              wr_pend_r;
    logic [WORD_W-1:0] wr_d0_r;
    logic [NLANE-1:0]  wr_m0_n_r;
    logic [NLANE-1:0]  wr_m1_n;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] mem [DEPTH];
    dps_out_state_t    st_r;
    logic [WORD_W-1:0] q_r;
    logic              cq_r;
    logic [$clog2(DLL_LOCK_CYC+1)-1:0] dll_cnt_r;

    // Address of word idx within a two-word linear burst
    function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                       input dps_burst_idx_t idx);
        burst_addr = base + ADDR_W'(idx);
    endfunction : burst_addr

    // Lane write masks, nibble masks for the 8-bit organisation
    function automatic logic [NLANE-1:0] lane_mask_n(input logic [MASK_W-1:0] bw_n,
                                                      input logic [1:0] nw_n);
        if (WORD_W == 8)
            lane_mask_n = NLANE'(nw_n);
        else
            lane_mask_n = NLANE'(bw_n);
    endfunction : lane_mask_n

    // All link inputs are pins and pass two flops first
    dps_sync #(.W(IN_W)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({lnk.k, lnk.k_n, lnk.c, lnk.c_n, lnk.read_select_n, lnk.write_select_n,
                lnk.delay_lock_off_n, lnk.shared_address_bus, lnk.write_data_in,
                lnk.byte_write_mask_n, lnk.nibble_write_mask_n}),
        .dout (in_s)
    );
    assign {k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s, dll_off_n_s,
            addr_s, d_s, bw_n_s, nw_n_s} = in_s;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            k_p_r  <= 1'b0;
            kn_p_r <= 1'b0;
            c_p_r  <= 1'b0;
            cn_p_r <= 1'b0;
        end else begin
            k_p_r  <= k_s;
            kn_p_r <= kn_s;
            c_p_r  <= c_s;
            cn_p_r <= cn_s;
        end
    end

    // Input clock edges sample the link requests, address and write data
    assign k_rise   = k_s & ~k_p_r;
    assign kn_rise  = kn_s & ~kn_p_r;
    // Output launch edges: K pair in single clock mode
    assign oc_rise  = single_r ? k_rise : (c_s & ~c_p_r);
    assign ocn_rise = single_r ? kn_rise : (cn_s & ~cn_p_r);

    // Single clock mode strapped once after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_cnt_r <= 2'h0;
            single_r    <= 1'b0;
        end else if (strap_cnt_r != 2'h3) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == 2'(`DPS_STRAP_CYC))
                single_r <= c_s & cn_s;
        end
    end

    // Read request and address taken on K
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_pend_r      <= 1'b0;
            rd_pend_addr_r <= '0;
            rd_arm_r       <= 1'b0;
            rd_arm_addr_r  <= '0;
        end else if (k_rise) begin
            rd_pend_r <= ~rsel_n_s;
            if (!rsel_n_s)
                rd_pend_addr_r <= addr_s;
        end else if (kn_rise) begin
            // Armed read launches on the next output C-bar
            rd_arm_r      <= rd_pend_r;
            rd_arm_addr_r <= rd_pend_addr_r;
            rd_pend_r     <= 1'b0;
        end
    end

    // Write: word0 at K, address and word1 at K-bar
    assign wr_addr = addr_s;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            wr_d0_r   <= '0;
            wr_m0_n_r <= '1;
        end else if (k_rise) begin
            wr_pend_r <= ~wsel_n_s;
            wr_d0_r   <= d_s;
            wr_m0_n_r <= lane_mask_n(bw_n_s, nw_n_s);
        end else if (kn_rise) begin
            wr_pend_r <= 1'b0;
        end
    end

    assign wr_m1_n = lane_mask_n(bw_n_s, nw_n_s);

    // Array update runs independently of the read pipeline
    always_ff @(posedge clk) begin
        if (kn_rise && wr_pend_r) begin
            for (int l = 0; l < NLANE; l++) begin
                if (!wr_m0_n_r[l])
                    mem[burst_addr(wr_addr, 2'h0)][l*LANE_W +: LANE_W] <=
                        wr_d0_r[l*LANE_W +: LANE_W];
                if (!wr_m1_n[l])
                    mem[burst_addr(wr_addr, 2'h1)][l*LANE_W +: LANE_W] <=
                        d_s[l*LANE_W +: LANE_W];
            end
        end
    end

    // Output sequencer: word0 on C-bar, word1 on C, then float at the next C-bar unless another read is armed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r         <= DPS_OUT_IDLE;
            q_r          <= '0;
            rd_w1_addr_r <= '0;
        end else begin
            case (st_r)
                DPS_OUT_IDLE, DPS_OUT_WORD1: begin
                    if (ocn_rise) begin
                        if (rd_arm_r) begin
                            q_r          <= mem[burst_addr(rd_arm_addr_r, 2'h0)];
                            rd_w1_addr_r <= burst_addr(rd_arm_addr_r, 2'h1);
                            st_r         <= DPS_OUT_WORD0;
                        end else begin
                            st_r <= DPS_OUT_IDLE;
                        end
                    end
                end
                DPS_OUT_WORD0: begin
                    if (oc_rise) begin
                        q_r  <= mem[rd_w1_addr_r];
                        st_r <= DPS_OUT_WORD1;
                    end
                end
                default: st_r <= DPS_OUT_IDLE;
            endcase
        end
    end

    assign lnk.read_data_out = q_r;
    assign lnk.read_data_oe  = (st_r != DPS_OUT_IDLE);
    assign out_state         = st_r;

    // Echo clock follows the launch clock, so it moves with the data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            cq_r <= 1'b0;
        else if (oc_rise)
            cq_r <= 1'b1;
        else if (ocn_rise)
            cq_r <= 1'b0;
    end
    assign lnk.echo_clock_out   = cq_r;
    assign lnk.echo_clock_out_n = ~cq_r;

    // Loop lock counter, held cleared while the loop is off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            dll_cnt_r <= '0;
        else if (!dll_off_n_s)
            dll_cnt_r <= '0;
        else if (k_rise && dll_cnt_r != DLL_LOCK_CYC)
            dll_cnt_r <= dll_cnt_r + 1'b1;
    end
    assign dll_locked        = (dll_cnt_r == DLL_LOCK_CYC);
    assign single_clock_mode = single_r;
endmodule : dps_dev
`default_nettype wire

// [rtl/dps_host.sv]
// Host end: memory controller driving the burst SRAM port
`include "dps_map.svh"
`default_nettype none
module dps_host #(
    parameter int WORD_W     = `DPS_WORD_W,
    parameter int MASK_W     = `DPS_MASK_W,
    parameter int ADDR_W     = `DPS_ADDR_W,
    parameter bit SINGLE_CLK = 1'b0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Link
    dps_if.host                    lnk,
    // Request
    output logic                   req_ready,
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] rd_addr,
    input  wire logic              wr_req,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WORD_W-1:0] wr_data0,
    input  wire logic [WORD_W-1:0] wr_data1,
    input  wire logic [MASK_W-1:0] wr_mask0_n,
    input  wire logic [MASK_W-1:0] wr_mask1_n,
    input  wire logic [1:0]        wr_nmask0_n,
    input  wire logic [1:0]        wr_nmask1_n,
    input  wire logic              dll_disable,
    // Read answer
    output logic                   rd_valid,
    output logic [WORD_W-1:0]      rd_data0,
    output logic [WORD_W-1:0]      rd_data1
);
    import dps_pkg::*;

    localparam int DIV = `DPS_K_DIV;
    localparam int PW  = $clog2(DIV);

    logic [PW-1:0]     ph_r;
    logic              c_r;
    logic [ADDR_W-1:0] wa_r;
    logic [WORD_W-1:0] wd1_r;
    logic [MASK_W-1:0] wm1_r;
    logic [1:0]        wn1_r;
    logic [WORD_W+3-1:0] in_s;
    logic [WORD_W-1:0] q_s;
    logic              oe_s, cq_s, cqn_s, cq_p_r, cqn_p_r, have0_r;

    // Input clock pair from a divider of clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            ph_r <= '0;
        else
            ph_r <= (ph_r == PW'(DIV - 1)) ? '0 : ph_r + 1'b1;
    end
    assign lnk.k   = (ph_r < PW'(DIV / 2));
    assign lnk.k_n = ~lnk.k;

    // Output clocks lag K by one cycle, or are tied high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            c_r <= 1'b0;
        else
            c_r <= lnk.k;
    end
    assign lnk.c   = SINGLE_CLK ? 1'b1 : c_r;
    assign lnk.c_n = SINGLE_CLK ? 1'b1 : ~c_r;

    assign req_ready = (ph_r == PW'(`DPS_K_SETUP_PH));
    assign lnk.delay_lock_off_n = ~dll_disable;

    // Pins set mid-phase, ahead of the K and K-bar rises
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lnk.read_select_n       <= 1'b1;
            lnk.write_select_n      <= 1'b1;
            lnk.shared_address_bus  <= '0;
            lnk.write_data_in       <= '0;
            lnk.byte_write_mask_n   <= '1;
            lnk.nibble_write_mask_n <= 2'h3;
            wa_r                    <= '0;
            wd1_r                   <= '0;
            wm1_r                   <= '1;
            wn1_r                   <= 2'h3;
        end else if (req_ready) begin
            lnk.read_select_n       <= ~rd_req;
            lnk.write_select_n      <= ~wr_req;
            lnk.shared_address_bus  <= rd_addr;
            lnk.write_data_in       <= wr_data0;
            lnk.byte_write_mask_n   <= wr_mask0_n;
            lnk.nibble_write_mask_n <= wr_nmask0_n;
            wa_r                    <= wr_addr;
            wd1_r                   <= wr_data1;
            wm1_r                   <= wr_mask1_n;
            wn1_r                   <= wr_nmask1_n;
        end else if (ph_r == PW'(`DPS_KN_SETUP_PH)) begin
            lnk.shared_address_bus  <= wa_r;
            lnk.write_data_in       <= wd1_r;
            lnk.byte_write_mask_n   <= wm1_r;
            lnk.nibble_write_mask_n <= wn1_r;
        end
    end

    dps_sync #(.W(WORD_W + 3)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({lnk.read_data_bus, lnk.read_data_oe, lnk.echo_clock_out,
                lnk.echo_clock_out_n}),
        .dout (in_s)
    );
    assign {q_s, oe_s, cq_s, cqn_s} = in_s;

    // Capture word0 on echo-bar, word1 on echo
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cq_p_r   <= 1'b0;
            cqn_p_r  <= 1'b0;
            have0_r  <= 1'b0;
            rd_valid <= 1'b0;
            rd_data0 <= '0;
            rd_data1 <= '0;
        end else begin
            cq_p_r   <= cq_s;
            cqn_p_r  <= cqn_s;
            rd_valid <= 1'b0;
            if (cqn_s && !cqn_p_r) begin
                have0_r <= oe_s;
                if (oe_s)
                    rd_data0 <= q_s;
            end else if (cq_s && !cq_p_r && have0_r && oe_s) begin
                rd_data1 <= q_s;
                rd_valid <= 1'b1;
                have0_r  <= 1'b0;
            end
        end
    end
endmodule : dps_host
`default_nettype wire

// [verification/dps_chk.sv]
// Concurrent checks on both directions of the host-device link of the burst SRAM port
`default_nettype none
module dps_chk #(
    parameter int WORD_W = 36,
    parameter int MASK_W = 4,
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // Input clocks and requests
    input wire logic              k,
    input wire logic              k_n,
    input wire logic              read_select_n,
    input wire logic              write_select_n,
    input wire logic [ADDR_W-1:0] shared_address_bus,
    input wire logic [WORD_W-1:0] write_data_in,
    input wire logic [MASK_W-1:0] byte_write_mask_n,
    // Read side
    input wire logic [WORD_W-1:0] read_data_out,
    input wire logic              read_data_oe,
    input wire logic              echo_clock_out,
    input wire logic              echo_clock_out_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Cycles since the last accepted read, saturating
    logic [5:0] rd_age_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_age_r <= 6'h3f;
        end else if ($rose(k) && !read_select_n) begin
            rd_age_r <= 6'h00;
        end else if (rd_age_r != 6'h3f) begin
            rd_age_r <= rd_age_r + 6'h01;
        end
    end

    property p_k_period;
        $rose(k) |=> !$rose(k) [*7] ##1 $rose(k);
    endproperty
    a_k_period: assert property (p_k_period)
        else $error("input clock period is not 8 cycles");
    property p_k_pair;
        k_n != k;
    endproperty
    a_k_pair: assert property (p_k_pair)
        else $error("input clock pair not complementary");
    property p_rd_hold;
        $rose(k) |=> $stable(read_select_n) && $stable(write_select_n)
            && $stable(shared_address_bus) && $stable(write_data_in);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("request moved at input clock rise");
    property p_wr_hold;
        $rose(k_n) |=> $stable(shared_address_bus) && $stable(write_data_in)
            && $stable(byte_write_mask_n);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write address or word1 moved at complementary rise");
    property p_rd_answer;
        $rose(k) && !read_select_n |-> ##[8:20] read_data_oe;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered in time");
    property p_burst_two;
        $rose(read_data_oe) |-> read_data_oe [*8];
    endproperty
    a_burst_two: assert property (p_burst_two)
        else $error("read burst shorter than two words");
    property p_oe_cause;
        read_data_oe |-> rd_age_r < 6'd40;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("read data driven without a read");
    property p_word_hold;
        $changed(read_data_out) && read_data_oe |=> $stable(read_data_out) [*3];
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("read word held less than half a period");
    property p_echo_pair;
        echo_clock_out != echo_clock_out_n;
    endproperty
    a_echo_pair: assert property (p_echo_pair)
        else $error("echo clocks not complementary");
    property p_echo_run;
        $rose(k) |-> ##[1:8] $changed(echo_clock_out);
    endproperty
    a_echo_run: assert property (p_echo_run)
        else $error("echo clock stopped");
    property p_echo_align;
        $rose(read_data_oe) |-> !echo_clock_out ##4 echo_clock_out;
    endproperty
    a_echo_align: assert property (p_echo_align)
        else $error("echo clock not aligned with read words");

    c_read: cover property ($rose(read_data_oe));
    c_stream: cover property (read_data_oe [*8] ##1 read_data_oe);
    c_write: cover property ($rose(k) && !write_select_n);
endmodule : dps_chk
`default_nettype wire

// [verification/testbench.sv]
// Bench joining host and device ends in dual and single clock mode
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dps_pkg::*;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  ra;
        logic [7:0]  wa;
        logic [35:0] d0;
        logic [35:0] d1;
        logic [3:0]  m0;
        logic [3:0]  m1;
    } dps_row_t;
    // Writes, a masked rewrite, a wrapping burst, then streamed reads
    localparam dps_row_t ROWS [8] = '{
        '{1'h0, 1'h1, 8'h00, 8'h10, 36'h111111111, 36'h222222222, 4'h0, 4'h0},
        '{1'h0, 1'h1, 8'h00, 8'hff, 36'h333333333, 36'h444444444, 4'h0, 4'h0},
        '{1'h0, 1'h1, 8'h00, 8'h10, 36'h555555555, 36'h666666666, 4'ha, 4'h5},
        '{1'h1, 1'h1, 8'h10, 8'h40, 36'h777777777, 36'h888888888, 4'h0, 4'h0},
        '{1'h1, 1'h0, 8'hff, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'h1, 1'h0, 8'h40, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'h0, 1'h1, 8'h00, 8'h40, 36'h999999999, 36'haaaaaaaaa, 4'hf, 4'hf},
        '{1'h1, 1'h0, 8'h40, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf}};

    logic           clk;
    logic           rstn;
    logic           rd_req;
    logic           wr_req;
    logic           dll_disable;
    logic [7:0]     rd_addr;
    logic [7:0]     wr_addr;
    logic [35:0]    wr_data0;
    logic [35:0]    wr_data1;
    logic [3:0]     wr_mask0_n;
    logic [3:0]     wr_mask1_n;
    logic [1:0]     wr_nmask0_n;
    logic [1:0]     wr_nmask1_n;
    logic           rdy [2];
    logic           vld [2];
    logic           lock [2];
    logic           scm [2];
    logic [35:0]    q0 [2];
    logic [35:0]    q1 [2];
    dps_out_state_t ost [2];
    logic [35:0]    mem [256];
    logic [71:0]    expq [$];
    int             failures;
    int             num_checks;
    int             cyc;

    // Pair 0 runs with output clocks, pair 1 with them tied high
    for (genvar i = 0; i < 2; i++) begin : g_pair
        logic [71:0] got [$];
        logic        oe_q;
        int          oe_rise;
        int          oe_high;
        dps_if #(.ADDR_W(8)) lnk ();
        dps_host #(.ADDR_W(8), .SINGLE_CLK(i == 1)) u_dps_host (
            .clk(clk), .rstn(rstn), .lnk(lnk), .req_ready(rdy[i]),
            .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req), .wr_addr(wr_addr),
            .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_mask0_n(wr_mask0_n),
            .wr_mask1_n(wr_mask1_n), .wr_nmask0_n(wr_nmask0_n), .wr_nmask1_n(wr_nmask1_n),
            .dll_disable(dll_disable), .rd_valid(vld[i]), .rd_data0(q0[i]), .rd_data1(q1[i]));
        dps_dev #(.ADDR_W(8), .DLL_LOCK_CYC(8)) u_dps_dev (
            .clk(clk), .rstn(rstn), .lnk(lnk), .dll_locked(lock[i]),
            .single_clock_mode(scm[i]), .out_state(ost[i]));
        always @(posedge clk) begin
            oe_q <= lnk.read_data_oe;
            if (vld[i] === 1'b1) got.push_back({q0[i], q1[i]});
            if (lnk.read_data_oe === 1'b1) oe_high++;
            if (lnk.read_data_oe === 1'b1 && oe_q !== 1'b1) oe_rise++;
        end
        if (i == 0) begin : g_chk
            dps_chk #(.ADDR_W(8)) u_dps_chk (
                .clk(clk), .rstn(rstn), .k(lnk.k), .k_n(lnk.k_n),
                .read_select_n(lnk.read_select_n), .write_select_n(lnk.write_select_n),
                .shared_address_bus(lnk.shared_address_bus),
                .write_data_in(lnk.write_data_in), .byte_write_mask_n(lnk.byte_write_mask_n),
                .read_data_out(lnk.read_data_out), .read_data_oe(lnk.read_data_oe),
                .echo_clock_out(lnk.echo_clock_out), .echo_clock_out_n(lnk.echo_clock_out_n));
        end
    end

    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Byte lanes of 9 bits, each written only while its mask is low
    task automatic put(input logic [7:0] a, input logic [35:0] d, input logic [3:0] m);
        for (int l = 0; l < 4; l++)
            if (!m[l]) mem[a][l*9 +: 9] = d[l*9 +: 9];
    endtask : put

    task automatic op(input dps_row_t r);
        int n;
        @(posedge clk);
        rd_req <= r.rd;
        wr_req <= r.wr;
        rd_addr <= r.ra;
        wr_addr <= r.wa;
        wr_data0 <= r.d0;
        wr_data1 <= r.d1;
        wr_mask0_n <= r.m0;
        wr_mask1_n <= r.m1;
        wr_nmask0_n <= r.m0[1:0];
        wr_nmask1_n <= r.m1[1:0];
        n = 0;
        @(negedge clk);
        while (rdy[0] !== 1'b1 && n < 16) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        if (r.wr) put(r.wa, r.d0, r.m0);
        if (r.wr) put(r.wa + 8'h01, r.d1, r.m1);
        if (r.rd) expq.push_back({mem[r.ra], mem[r.ra + 8'h01]});
    endtask : op

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            $display("ERROR run time expected 6000 seen %0d", cyc);
            results();
        end
    end

    initial begin
        int n;
        rstn = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        dll_disable = 1'b0;
        rd_addr = 8'h00;
        wr_addr = 8'h00;
        wr_data0 = 36'h0;
        wr_data1 = 36'h0;
        wr_mask0_n = 4'hf;
        wr_mask1_n = 4'hf;
        wr_nmask0_n = 2'h3;
        wr_nmask1_n = 2'h3;
        repeat (4) @(posedge clk);
        chk("bus in reset", 72'h0, 72'(g_pair[0].lnk.read_data_oe));
        rstn <= 1'b1;
        n = 0;
        while (lock[0] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("lock", 72'h1, 72'(lock[0]));
        chk("strap dual", 72'h0, 72'(scm[0]));
        chk("strap single", 72'h1, 72'(scm[1]));
        foreach (ROWS[r]) op(ROWS[r]);
        n = 0;
        while ((g_pair[0].got.size() < 4 || g_pair[1].got.size() < 4) && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (24) @(posedge clk);
        foreach (expq[j]) begin
            chk("read dual", expq[j], g_pair[0].got[j]);
            chk("read single", expq[j], g_pair[1].got[j]);
        end
        chk("reads", 72'h4, 72'(g_pair[0].got.size()));
        chk("oe rises", 72'h2, 72'(g_pair[0].oe_rise));
        chk("oe cycles", 72'd32, 72'(g_pair[0].oe_high));
        chk("deselect", 72'h0, 72'(g_pair[0].lnk.read_data_oe));
        chk("out state", 72'(DPS_OUT_IDLE), 72'(ost[0]));
        dll_disable <= 1'b1;
        n = 0;
        while (lock[0] !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("lock off", 72'h0, 72'(lock[0]));
        dll_disable <= 1'b0;
        n = 0;
        while (lock[0] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("relock time", 72'h1, 72'(n >= 60 && lock[0] === 1'b1));
        rstn <= 1'b0;
        @(negedge clk);
        chk("bus reset again", 72'h0, 72'(g_pair[0].lnk.read_data_oe));
        chk("lock reset", 72'h0, 72'(lock[0]));
        chk("state reset", 72'(DPS_OUT_IDLE), 72'(ost[0]));
        @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        results();
    end
endmodule : testbench
`default_nettype wire
